// ### hdl/rsie_core.v
// Shortcut matrix, event flags and interrupt enables behind classic Wishbone.
// Assumes one clock, synchronous reset, radio events as one-cycle pulses.
`timescale 1ns/100ps
`include "rsie_regs.vh"

module rsie_core #(
  parameter BC_W = 16,
  parameter SS_W = 7
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`RSIE_ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [31:0] event_i,
  input wire ss_sample_valid_i,
  input wire [SS_W-1:0] ss_sample_i,
  input wire [BC_W-1:0] bit_count_i,
  input wire bc_running_i,
  input wire preamble_hit_i,
  input wire rx_active_i,
  input wire [`RSIE_MODE_W-1:0] mode_i,
  output reg [`RSIE_TK_W-1:0] task_o,
  output reg irq_o
);

  reg [31:0] event_task_links;
  reg [31:0] irq_enable;
  reg [31:0] evt_flags;
  reg [BC_W-1:0] bit_count_compare;
  reg [SS_W-1:0] ss_sample;
  reg [`RSIE_TK_W-1:0] next_task;
  reg [31:0] rd_mux;
  wire ss_done;
  wire bc_reached;
  wire preamble;
  wire [31:0] ev;
  wire access;
  wire wr;
  wire [31:0] wmask;
  wire [31:0] wdata_m;

  // Events produced from datapath status
  rsie_event_cond #(
    .BC_W(BC_W)
  ) u_cond (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ss_sample_valid_i(ss_sample_valid_i),
    .bit_count_i(bit_count_i),
    .bc_running_i(bc_running_i),
    .bit_count_compare_i(bit_count_compare),
    .preamble_hit_i(preamble_hit_i),
    .rx_active_i(rx_active_i),
    .mode_i(mode_i),
    .ss_done_o(ss_done),
    .bc_reached_o(bc_reached),
    .preamble_o(preamble)
  );

  // Merge internal events over the external vector, unused bits dropped
  assign ev = ((event_i & ~((32'h1 << `RSIE_EV_SS_DONE) | (32'h1 << `RSIE_EV_BC_REACHED) |
               (32'h1 << `RSIE_EV_PREAMBLE))) |
               ({31'h0, ss_done} << `RSIE_EV_SS_DONE) |
               ({31'h0, bc_reached} << `RSIE_EV_BC_REACHED) |
               ({31'h0, preamble} << `RSIE_EV_PREAMBLE)) & `RSIE_EV_MASK;

  // Bus decode; ack is one cycle after the strobe and never back to back
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = access && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata_m = wb_dat_i & wmask;

  // Shortcut matrix: each link turns an event into a task pulse
  always @* begin
    next_task = {`RSIE_TK_W{1'b0}};
    next_task[`RSIE_TK_START] =
      (event_task_links[`RSIE_SC_READY_START] && ev[`RSIE_EV_READY]) ||
      (event_task_links[`RSIE_SC_END_START] && ev[`RSIE_EV_END]) ||
      (event_task_links[`RSIE_SC_TRANSMIT_PATH_READY_START] && ev[`RSIE_EV_TRANSMIT_PATH_READY]) ||
      (event_task_links[`RSIE_SC_RECEIVE_PATH_READY_START] && ev[`RSIE_EV_RECEIVE_PATH_READY]) ||
      (event_task_links[`RSIE_SC_LASTBIT_START] && ev[`RSIE_EV_LASTBIT]);
    next_task[`RSIE_TK_DISABLE] =
      (event_task_links[`RSIE_SC_END_DISABLE] && ev[`RSIE_EV_END]) ||
      (event_task_links[`RSIE_SC_OCCUPIED_DISABLE] && ev[`RSIE_EV_OCCUPIED]) ||
      (event_task_links[`RSIE_SC_EDDONE_DISABLE] && ev[`RSIE_EV_ED_DONE]) ||
      (event_task_links[`RSIE_SC_LASTBIT_DISABLE] && ev[`RSIE_EV_LASTBIT]);
    next_task[`RSIE_TK_TXRAMP] =
      (event_task_links[`RSIE_SC_DISABLED_TRANSMIT_RAMP_UP] && ev[`RSIE_EV_DISABLED]) ||
      (event_task_links[`RSIE_SC_CLEAR_TXRAMP] && ev[`RSIE_EV_CLEAR]);
    next_task[`RSIE_TK_RXRAMP] =
      event_task_links[`RSIE_SC_DISABLED_RXEN] && ev[`RSIE_EV_DISABLED];
    next_task[`RSIE_TK_SS_START] =
      event_task_links[`RSIE_SC_ADDRESS_SSSTART] && ev[`RSIE_EV_ADDRESS];
    next_task[`RSIE_TK_SS_STOP] =
      event_task_links[`RSIE_SC_DISABLED_SSSTOP] && ev[`RSIE_EV_DISABLED];
    next_task[`RSIE_TK_BC_START] =
      (event_task_links[`RSIE_SC_ADDRESS_BIT_COUNTER_START] && ev[`RSIE_EV_ADDRESS]) ||
      (event_task_links[`RSIE_SC_FRAME_BIT_COUNTER_START] && ev[`RSIE_EV_FRAME_SEEN]);
    next_task[`RSIE_TK_CCA_START] =
      event_task_links[`RSIE_SC_RECEIVE_PATH_READY_CCA] && ev[`RSIE_EV_RECEIVE_PATH_READY];
    next_task[`RSIE_TK_ED_START] =
      event_task_links[`RSIE_SC_READY_ENERGY_DETECT_START] && ev[`RSIE_EV_READY];
    next_task[`RSIE_TK_STOP] =
      event_task_links[`RSIE_SC_CLEAR_STOP] && ev[`RSIE_EV_CLEAR];
  end

  // Read mux; unmapped offsets read as zero and still acknowledge
  always @* begin
    case (wb_adr_i)
      `RSIE_OFF_LINKS: rd_mux = event_task_links;
      `RSIE_OFF_IRQ_SET: rd_mux = irq_enable;
      `RSIE_OFF_IRQ_CLR: rd_mux = irq_enable;
      `RSIE_OFF_EVT_FLAGS: rd_mux = evt_flags;
      `RSIE_OFF_BC_COMPARE: rd_mux = {{(32-BC_W){1'b0}}, bit_count_compare};
      `RSIE_OFF_SS_SAMPLE: rd_mux = {{(32-SS_W){1'b0}}, ss_sample};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Task pulses are registered so the outputs come straight from flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      task_o <= {`RSIE_TK_W{1'b0}};
    end else begin
      task_o <= next_task;
    end
  end

  // Bus slave and writable registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      event_task_links <= `RSIE_LINKS_RESET;
      irq_enable <= `RSIE_IRQ_RESET;
      bit_count_compare <= {BC_W{1'b0}};
    end else begin
      wb_ack_o <= access;
      if (access && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
      if (wr && wb_adr_i == `RSIE_OFF_LINKS) begin
        event_task_links <= ((event_task_links & ~wmask) | wdata_m) & `RSIE_SC_MASK;
      end
      // Zero bits leave enables alone; only written ones act
      if (wr && wb_adr_i == `RSIE_OFF_IRQ_SET) begin
        irq_enable <= irq_enable | (wdata_m & `RSIE_EV_MASK);
      end
      if (wr && wb_adr_i == `RSIE_OFF_IRQ_CLR) begin
        irq_enable <= irq_enable & ~wdata_m;
      end
      if (wr && wb_adr_i == `RSIE_OFF_BC_COMPARE) begin
        bit_count_compare <= (bit_count_compare & wmask[BC_W-1:0]) ^ bit_count_compare ^
                             (wb_dat_i[BC_W-1:0] & wmask[BC_W-1:0]);
      end
    end
  end

  // Sample is captured with the done event so software reads the new value
  always @(posedge clk_i) begin
    if (rst_i) begin
      ss_sample <= {SS_W{1'b0}};
    end else if (ss_sample_valid_i) begin
      ss_sample <= ss_sample_i;
    end
  end

  // Sticky event flags; software clears with write-one, a new event wins
  always @(posedge clk_i) begin
    if (rst_i) begin
      evt_flags <= 32'h00000000;
    end else if (wr && wb_adr_i == `RSIE_OFF_EVT_FLAGS) begin
      evt_flags <= (evt_flags & ~wdata_m) | ev;
    end else begin
      evt_flags <= evt_flags | ev;
    end
  end

  // Interrupt line from registered flags and enables
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(evt_flags & irq_enable);
    end
  end

endmodule // rsie_core

// ### include/rsie_regs.vh
// Register map and field layout of the event shortcut and interrupt enable block.
// Included by the design files; definitions only.
`ifndef RSIE_REGS_VH
`define RSIE_REGS_VH

// Byte offsets on the register bus
`define RSIE_OFF_LINKS 12'h200
`define RSIE_OFF_IRQ_SET 12'h304
`define RSIE_OFF_IRQ_CLR 12'h308
`define RSIE_OFF_EVT_FLAGS 12'h10c
`define RSIE_OFF_BC_COMPARE 12'h110
`define RSIE_OFF_SS_SAMPLE 12'h114
`define RSIE_ADDR_W 12

// Reset values
`define RSIE_LINKS_RESET 32'h00000000
`define RSIE_IRQ_RESET 32'h00000000

// Shortcut field positions in event_task_links
`define RSIE_SC_READY_START 0
`define RSIE_SC_END_DISABLE 1
`define RSIE_SC_DISABLED_TRANSMIT_RAMP_UP 2
`define RSIE_SC_DISABLED_RXEN 3
`define RSIE_SC_ADDRESS_SSSTART 4
`define RSIE_SC_END_START 5
`define RSIE_SC_ADDRESS_BIT_COUNTER_START 6
`define RSIE_SC_DISABLED_SSSTOP 8
`define RSIE_SC_RECEIVE_PATH_READY_CCA 11
`define RSIE_SC_CLEAR_TXRAMP 12
`define RSIE_SC_OCCUPIED_DISABLE 13
`define RSIE_SC_FRAME_BIT_COUNTER_START 14
`define RSIE_SC_READY_ENERGY_DETECT_START 15
`define RSIE_SC_EDDONE_DISABLE 16
`define RSIE_SC_CLEAR_STOP 17
`define RSIE_SC_TRANSMIT_PATH_READY_START 18
`define RSIE_SC_RECEIVE_PATH_READY_START 19
`define RSIE_SC_LASTBIT_DISABLE 20
`define RSIE_SC_LASTBIT_START 21
`define RSIE_SC_MASK 32'h003ff97f

// Event bit positions (same layout in both enable registers)
`define RSIE_EV_READY 0
`define RSIE_EV_ADDRESS 1
`define RSIE_EV_PAYLOAD 2
`define RSIE_EV_END 3
`define RSIE_EV_DISABLED 4
`define RSIE_EV_DEVMATCH 5
`define RSIE_EV_DEVMISS 6
`define RSIE_EV_SS_DONE 7
`define RSIE_EV_BC_REACHED 10
`define RSIE_EV_CRCOK 12
`define RSIE_EV_CRCERR 13
`define RSIE_EV_FRAME_SEEN 14
`define RSIE_EV_ED_DONE 15
`define RSIE_EV_ED_STOPPED 16
`define RSIE_EV_CLEAR 17
`define RSIE_EV_OCCUPIED 18
`define RSIE_EV_CCA_STOPPED 19
`define RSIE_EV_RATEBOOST 20
`define RSIE_EV_TRANSMIT_PATH_READY 21
`define RSIE_EV_RECEIVE_PATH_READY 22
`define RSIE_EV_MHRMATCH 23
`define RSIE_EV_PREAMBLE 26
`define RSIE_EV_LASTBIT 27
`define RSIE_EV_TONE_EXT 28
`define RSIE_EV_MASK 32'h1cfff4ff

// Task bit positions on the task output vector
`define RSIE_TK_START 0
`define RSIE_TK_DISABLE 1
`define RSIE_TK_TXRAMP 2
`define RSIE_TK_RXRAMP 3
`define RSIE_TK_SS_START 4
`define RSIE_TK_SS_STOP 5
`define RSIE_TK_BC_START 6
`define RSIE_TK_CCA_START 7
`define RSIE_TK_ED_START 8
`define RSIE_TK_STOP 9
`define RSIE_TK_W 10

// Radio modes that allow the preamble-seen event
`define RSIE_MODE_W 4
`define RSIE_MODE_LR125K 4'h5
`define RSIE_MODE_LR500K 4'h6
`define RSIE_MODE_PAN250K 4'hf

`endif

// ### hdl/rsie_event_cond.v
// Event qualifier: derives three events from radio datapath status.
// Assumes all inputs are synchronous to clk_i.
`timescale 1ns/100ps
`include "rsie_regs.vh"

module rsie_event_cond #(
  parameter BC_W = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire ss_sample_valid_i,
  input wire [BC_W-1:0] bit_count_i,
  input wire bc_running_i,
  input wire [BC_W-1:0] bit_count_compare_i,
  input wire preamble_hit_i,
  input wire rx_active_i,
  input wire [`RSIE_MODE_W-1:0] mode_i,
  output reg ss_done_o,
  output reg bc_reached_o,
  output reg preamble_o
);

  reg bc_hit_q;
  wire bc_hit;
  wire lr_mode;

  assign bc_hit = bc_running_i && (bit_count_i == bit_count_compare_i);
  assign lr_mode = (mode_i == `RSIE_MODE_LR125K) || (mode_i == `RSIE_MODE_LR500K) ||
                   (mode_i == `RSIE_MODE_PAN250K);

  // ss_done and preamble follow their inputs a cycle later; only the compare fires once on the match edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      ss_done_o <= 1'b0;
      bc_reached_o <= 1'b0;
      preamble_o <= 1'b0;
      bc_hit_q <= 1'b0;
    end else begin
      ss_done_o <= ss_sample_valid_i;
      bc_hit_q <= bc_hit;
      bc_reached_o <= bc_hit && !bc_hit_q;
      // Detector may fire falsely; no filtering is attempted
      preamble_o <= preamble_hit_i && rx_active_i && lr_mode;
    end
  end

endmodule // rsie_event_cond

// ### tb/rsie_core_sva.sv
// Checker for the shortcut and interrupt enable core, watching its ports only.
// Assumes classic Wishbone masters and radio events kept clear of bus writes.
`timescale 1ns/100ps
`include "rsie_regs.vh"
module rsie_core_sva #(
  parameter BC_W = 16,
  parameter SS_W = 7
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`RSIE_ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [31:0] event_i,
  input wire ss_sample_valid_i,
  input wire [SS_W-1:0] ss_sample_i,
  input wire [BC_W-1:0] bit_count_i,
  input wire bc_running_i,
  input wire preamble_hit_i,
  input wire rx_active_i,
  input wire [`RSIE_MODE_W-1:0] mode_i,
  input wire [`RSIE_TK_W-1:0] task_o,
  input wire irq_o
);
  reg [31:0] lk;
  reg [31:0] en;
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
  wire [31:0] bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Shadow links and enables, updated at the taking edge just as the core does
  always @(posedge clk_i) begin
    if (rst_i) begin
      lk <= 32'h0;
      en <= 32'h0;
    end else if (take) begin
      if (wb_adr_i == `RSIE_OFF_LINKS) lk <= (lk & ~bm) | (wb_dat_i & bm & `RSIE_SC_MASK);
      if (wb_adr_i == `RSIE_OFF_IRQ_SET) en <= en | (wb_dat_i & bm & `RSIE_EV_MASK);
      if (wb_adr_i == `RSIE_OFF_IRQ_CLR) en <= en & ~(wb_dat_i & bm);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  ready_start_a: assert property (event_i[0] && lk[0] |=> task_o[0])
    else $error("ready did not start");
  addr_bit_counter_start_a: assert property (event_i[1] && lk[6] |=> task_o[6])
    else $error("address did not start counter");
  clear_ramp_a: assert property (event_i[17] && lk[12] |-> ##1 task_o[2])
    else $error("clear did not ramp up");
  lastbit_pair_a: assert property (event_i[27] && lk[20] && lk[21] |=> &task_o[1:0])
    else $error("last bit links not both fired");
  bc_cause_a: assert property (task_o[6] |->
    $past(event_i[1] && lk[6] || event_i[14] && lk[14]))
    else $error("counter start without linked event");
  irq_off_a: assert property (en == 32'h0 |=> !irq_o) else $error("irq while disabled");
  irq_on_a: assert property (|(event_i & en & 32'h18fff07f) |=> ##1 irq_o)
    else $error("enabled event gave no irq");
  cover property (event_i[0] && lk[0]);
  cover property (task_o[6]);
  cover property (irq_o);
endmodule // rsie_core_sva

bind rsie_core rsie_core_sva #(.BC_W(BC_W), .SS_W(SS_W)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .event_i(event_i), .ss_sample_valid_i(ss_sample_valid_i), .ss_sample_i(ss_sample_i),
  .bit_count_i(bit_count_i), .bc_running_i(bc_running_i), .preamble_hit_i(preamble_hit_i),
  .rx_active_i(rx_active_i), .mode_i(mode_i), .task_o(task_o), .irq_o(irq_o));

// ### tb/test_radio_shortcut_irq_enable.sv
// Self-checking bench for the shortcut and interrupt enable core.
// Assumes one registered ack per bus cycle and one-cycle radio event pulses.
`timescale 1ns/100ps
`include "rsie_regs.vh"
module test_radio_shortcut_irq_enable;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, bc_run = 0, pre = 0, rx = 0, ssv = 0;
  logic [11:0] adr = 0;
  logic [3:0] sel = 0, mode = 0;
  logic [31:0] dat = 0, ev = 0, rd, wb_dat_o;
  logic [15:0] bcnt = 0;
  logic [6:0] ss = 0;
  logic [9:0] task_o, tk;
  logic wb_ack_o, irq_o;
  logic [3:0] md[4] = '{4'h5, 4'h6, 4'hf, 4'h0};
  int n_fail = 0, checked = 0;
  // Shortcut table: event bit, link bit, task bit
  int te[19] = '{0, 3, 4, 4, 1, 3, 1, 4, 22, 17, 18, 14, 0, 15, 17, 21, 22, 27, 27};
  int tl[19] = '{0, 1, 2, 3, 4, 5, 6, 8, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
  int tt[19] = '{0, 1, 2, 3, 4, 0, 6, 5, 7, 2, 1, 6, 8, 1, 9, 0, 0, 1, 0};
  initial forever #10 clk_i = ~clk_i;
  rsie_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .event_i(ev), .ss_sample_valid_i(ssv), .ss_sample_i(ss), .bit_count_i(bcnt),
    .bc_running_i(bc_run), .preamble_hit_i(pre), .rx_active_i(rx), .mode_i(mode),
    .task_o(task_o), .irq_o(irq_o));
  task stop_test;
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; a silent slave is caught by the watchdog, not here
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    wb(0, a, 0, 4'hf);
    chk(rd, e);
  endtask
  // Event pulse; tasks stand one cycle only, so they are caught right after
  // the sampling edge; returns once flags and the interrupt have settled
  task pulse(input logic [31:0] e);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= 0;
    #1;
    tk = task_o;
    @(posedge clk_i);
    #1;
  endtask
  function logic [31:0] exp_task(input logic [31:0] l, input logic [31:0] e);
    exp_task = 0;
    for (int i = 0; i < 19; i++)
      if (l[tl[i]] && e[te[i]]) exp_task[tt[i]] = 1'b1;
  endfunction
  initial begin
    #200000;
    n_fail++;
    stop_test;
  end
  initial begin
    logic [31:0] r, c;
    void'($urandom(41427));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    rc(`RSIE_OFF_LINKS, 0);
    rc(`RSIE_OFF_IRQ_SET, 0);
    rc(`RSIE_OFF_IRQ_CLR, 0);
    wb(1, `RSIE_OFF_LINKS, 32'hffffffff, 4'hf);
    rc(`RSIE_OFF_LINKS, `RSIE_SC_MASK);
    pulse(32'hffffffff);
    chk({22'h0, tk}, exp_task(`RSIE_SC_MASK, 32'hffffffff));
    // Random links against sparse event bursts; several links may share a task
    for (int k = 0; k < 80; k++) begin
      r = $urandom;
      c = $urandom & $urandom;
      wb(1, `RSIE_OFF_LINKS, r, 4'hf);
      pulse(c);
      chk({22'h0, tk}, exp_task(r, c));
    end
    wb(1, `RSIE_OFF_LINKS, 0, 4'hf);
    pulse(32'hffffffff);
    chk({22'h0, tk}, 0);
    r = $urandom;
    c = $urandom;
    wb(1, `RSIE_OFF_IRQ_CLR, 32'hffffffff, 4'hf);
    wb(1, `RSIE_OFF_IRQ_SET, r, 4'hf);
    rc(`RSIE_OFF_IRQ_CLR, r & `RSIE_EV_MASK);
    wb(1, `RSIE_OFF_IRQ_CLR, c, 4'hf);
    wb(1, `RSIE_OFF_IRQ_SET, 0, 4'hf);
    wb(1, `RSIE_OFF_IRQ_CLR, 0, 4'hf);
    rc(`RSIE_OFF_IRQ_SET, r & ~c & `RSIE_EV_MASK);
    wb(1, `RSIE_OFF_IRQ_SET, 32'hffffffff, 4'h8);
    rc(`RSIE_OFF_IRQ_SET, (r & ~c | 32'hff000000) & `RSIE_EV_MASK);
    wb(1, 12'h3fc, 32'hffffffff, 4'hf);
    rc(12'h3fc, 0);
    // Interrupt raised, masked by the enable, and cleared through the flags
    wb(1, `RSIE_OFF_IRQ_CLR, 32'hffffffff, 4'hf);
    wb(1, `RSIE_OFF_EVT_FLAGS, 32'hffffffff, 4'hf);
    wb(1, `RSIE_OFF_IRQ_SET, 32'h1 << `RSIE_EV_TONE_EXT, 4'hf);
    pulse(32'h1 << `RSIE_EV_READY);
    chk(irq_o, 0);
    pulse(32'h1 << `RSIE_EV_TONE_EXT);
    chk(irq_o, 1);
    wb(1, `RSIE_OFF_IRQ_CLR, 32'h1 << `RSIE_EV_TONE_EXT, 4'hf);
    pulse(0);
    chk(irq_o, 0);
    wb(1, `RSIE_OFF_IRQ_SET, 32'hffffffff, 4'hf);
    pulse(0);
    chk(irq_o, 1);
    wb(1, `RSIE_OFF_EVT_FLAGS, 32'hffffffff, 4'hf);
    pulse(0);
    chk(irq_o, 0);
    // Internal events: strength sample, counter match, preamble per mode
    @(posedge clk_i);
    ss <= $urandom;
    ssv <= 1;
    @(posedge clk_i);
    ssv <= 0;
    r = {25'h0, ss};
    pulse(0);
    rc(`RSIE_OFF_SS_SAMPLE, r);
    rc(`RSIE_OFF_EVT_FLAGS, 32'h80);
    wb(1, `RSIE_OFF_EVT_FLAGS, 32'hffffffff, 4'hf);
    wb(1, `RSIE_OFF_BC_COMPARE, 32'h55, 4'hf);
    bc_run <= 1;
    bcnt <= 16'h54;
    pulse(0);
    bcnt <= 16'h55;
    pulse(0);
    rc(`RSIE_OFF_EVT_FLAGS, 32'h400);
    rx <= 1;
    foreach (md[i]) begin
      wb(1, `RSIE_OFF_EVT_FLAGS, 32'hffffffff, 4'hf);
      mode <= md[i];
      pulse(0);
      pre <= 1;
      @(posedge clk_i);
      pre <= 0;
      pulse(0);
      rc(`RSIE_OFF_EVT_FLAGS, md[i] == 4'h0 ? 32'h0 : 32'h04000000);
    end
    stop_test;
  end
endmodule // test_radio_shortcut_irq_enable
